/* File: verilog/wat_pkg.sv */
// Package with register map, field layouts, reset values and carrier types.
package wat_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CKPER = 8'h08;
  localparam logic [7:0] ADDR_LAT = 8'h0c;
  localparam int MODE_TRAIN = 0;
  localparam int MODE_INV01 = 1;
  localparam int MODE_INV23 = 2;
  localparam int MODE_AUTOSYNC = 3;
  localparam int MODE_STOP_PD = 4;
  localparam int MODE_NO_REF_TRAIN = 5;
  localparam int MODE_PIN = 6;
  localparam int MODE_RD_INV = 7;
  localparam int MODE_WR_INV = 8;
  localparam int MODE_RD_CHK = 9;
  localparam int MODE_WR_CHK = 10;
  localparam logic [10:0] MODE_RESET = 11'h000;
  localparam logic [3:0] LAT_RESET = 4'h4;
  localparam logic [3:0] EDC_HOLD = 4'hf;
  localparam int WCK_STOP_CYCLES = 8;
  localparam int CK_PERIOD_MIN_CYCLES = 10;

  typedef struct packed {
    logic act;
    logic pre;
    logic ref_cmd;
    logic pde;
    logic pdx;
    logic sre;
    logic rd;
    logic fifo_load;
    logic train_read;
  } wat_cmd_t;

  typedef struct packed {
    logic wr_chk;
    logic rd_chk;
    logic wr_inv;
    logic rd_inv;
    logic pin_mode;
    logic no_ref_train;
    logic stop_pd;
    logic autosync;
    logic inv23;
    logic inv01;
    logic train;
  } wat_mode_t;
endpackage

/* File: verilog/wat_divider.sv */
// WCK pin synchroniser and divide-by-2 circuit with stop detection.
`timescale 1ns/1ns
module wat_divider #(
  parameter int STOP_CYCLES = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wck,
  input wire logic i_reset_div,
  output logic o_div,
  output logic o_stopped
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic [7:0] idle_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_wck;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_q <= 8'h00;
    end else if (sync_q != prev_q) begin
      idle_q <= 8'h00;
    end else if (idle_q != 8'(STOP_CYCLES)) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  assign o_stopped = (idle_q == 8'(STOP_CYCLES));

  // Held in reset while stopped; the first edge after restart falls inside the reset, so both toggle in phase from the second edge.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_div <= 1'b0;
    end else if (i_reset_div) begin
      o_div <= 1'b0; // [RQ9]
    end else if (sync_q && !prev_q) begin
      o_div <= ~o_div;
    end
  end
endmodule

/* File: verilog/wat_top.sv */
// WCK-to-CK alignment and read-training support logic of the memory device.
// Contract
// (RQ1) After power-down exit with auto-sync, controller briefly issues training command.
// (RQ2) After power-down exit, controller waits exit delay, or PLL lock time.
// (RQ3) Auto-sync works in normal and pin modes, only up to a maximum frequency.
// (RQ4) Phase search needed at 2Gbps and above; below only if dividers aligned.
// (RQ5) Controller using WCK stop for divider setup leaves auto-sync cleared.
// (RQ6) Without clock stop, controller enables training, sweeps phase, flips a divider.
// (RQ7) Controller resets PLL, waits lock, exits training aligned, waits delay.
// (RQ8) With clock stop, controller parks WCK, waits, enables training, restarts cleanly.
// (RQ9) Training enabled while WCK stopped resets both dividers, keeping them in phase.
// (RQ10) Latencies count on CK; WCK offset shows as a latency shift.
// (RQ11) Unshared WCK: controller sets each phase to its ideal point.
// (RQ12) Shared WCK: controller uses midpoint within synchronisation tolerance.
// (RQ13) Shared chip select: soft select bits direct divider inversion to one device.
// (RQ14) Read training needs open bank or refresh enabling, alignment done, PLL locked.
// (RQ15) Refresh-enabled WCK tree ends on activate, power-down or self refresh.
// (RQ16) Inversion and check enables must be set throughout read training.
// (RQ17) FIFO load and training read never touch the array; no mode entry needed.
// (RQ18) Controller allows 10 ns from activate to FIFO load or training read.
// (RQ19) Controller allows 10 ns from refresh to training read or write.
// (RQ20) Training reads 2 CK apart; FIFO loads 4 CK apart.
// (RQ21) After FIFO load to position 111, next load waits 4 CK.
// (RQ22) FIFO load to last position then training read needs 4 CK.
// (RQ23) Read or training read then FIFO load needs 4 CK.
// (RQ24) Mode bit train set enters alignment training, cleared leaves it.
// (RQ25) Each CK edge, early divided WCK drives 1111 on EDC, late drives 0000. The code updates one EDC bit per pair, on CK rising edges only.
// (RQ26) Two mode bits invert the divider of each WCK pair.
// (RQ27) Auto-sync acts only with stop-in-power-down set and WCK stopped.
// (RQ28) Controller counts waits in whole CK cycles, rounding up.
`timescale 1ns/1ns
module wat_top #(
  parameter int STOP_CYCLES = wat_pkg::WCK_STOP_CYCLES,
  parameter int CK_PERIOD_MIN = wat_pkg::CK_PERIOD_MIN_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ck,
  input wire logic i_wck01,
  input wire logic i_wck23,
  input wire wat_pkg::wat_cmd_t i_cmd,
  output logic o_edc0,
  output logic o_edc2,
  output logic o_array_access,
  output logic o_rd_data_start,
  output logic o_wck_tree_en
);
  logic rst_meta_q;
  logic rst_n;
  logic [2:0] ck_sync_q;
  wat_pkg::wat_cmd_t cmd_meta_q;
  wat_pkg::wat_cmd_t cmd_q;
  wat_pkg::wat_mode_t mode_q;
  logic [3:0] lat_q;
  logic [15:0] ck_per_q;
  logic [15:0] ck_cnt_q;
  logic ck_rise;
  logic [1:0] div;
  logic [1:0] stopped;
  logic [1:0] inv;
  logic [1:0] early_q;
  logic in_pd_q;
  logic bank_open_q;
  logic ref_tree_q;
  logic autosync_ok;
  logic reset_div;
  logic [3:0] lat_cnt_q;
  logic lat_run_q;
  logic setup;
  logic access;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // CK and commands cross from the pins; commands are taken only on a CK rising edge.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ck_sync_q <= 3'h0;
      cmd_meta_q <= '0;
      cmd_q <= '0;
    end else begin
      ck_sync_q <= {ck_sync_q[1:0], i_ck};
      cmd_meta_q <= i_cmd;
      cmd_q <= cmd_meta_q;
    end
  end

  assign ck_rise = ck_sync_q[1] && !ck_sync_q[2];

  // CK period in mclk cycles, used to judge the auto-sync frequency limit.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ck_cnt_q <= 16'h0000;
      ck_per_q <= 16'h0000;
    end else if (ck_rise) begin
      ck_cnt_q <= 16'h0001;
      ck_per_q <= ck_cnt_q;
    end else if (ck_cnt_q != 16'hffff) begin
      ck_cnt_q <= ck_cnt_q + 16'h0001;
    end
  end

  assign autosync_ok = (ck_per_q >= 16'(CK_PERIOD_MIN)); // [RQ3]
  assign inv = {mode_q.inv23, mode_q.inv01}; // [RQ26]
  // Dividers reset when training is enabled with WCK parked, or on auto-sync in power-down.
  assign reset_div = (mode_q.train && (&stopped)) // [RQ9] [RQ24]
    || (mode_q.autosync && mode_q.stop_pd && in_pd_q && (&stopped) && autosync_ok); // [RQ27]

  for (genvar g = 0; g < 2; g++) begin : g_div
    wat_divider #(
      .STOP_CYCLES(STOP_CYCLES)
    ) u_div (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_wck(g == 0 ? i_wck01 : i_wck23),
      .i_reset_div(reset_div),
      .o_div(div[g]),
      .o_stopped(stopped[g])
    );
  end

  // Phase detector: divided WCK sampled once per CK; high means early.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      early_q <= 2'b00;
      o_edc0 <= 1'b1;
      o_edc2 <= 1'b1;
    end else if (!mode_q.train) begin
      o_edc0 <= wat_pkg::EDC_HOLD[0];
      o_edc2 <= wat_pkg::EDC_HOLD[0];
    end else if (ck_rise) begin
      early_q <= div ^ inv; // [RQ26]
      o_edc0 <= (div[0] ^ inv[0]) ? wat_pkg::EDC_HOLD[0] : ~wat_pkg::EDC_HOLD[0]; // [RQ25]
      o_edc2 <= (div[1] ^ inv[1]) ? wat_pkg::EDC_HOLD[0] : ~wat_pkg::EDC_HOLD[0]; // [RQ25]
    end
  end

  // Bank, power-down and refresh-enabled WCK tree tracking.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open_q <= 1'b0;
      ref_tree_q <= 1'b0;
      in_pd_q <= 1'b0;
      o_wck_tree_en <= 1'b0;
    end else begin
      if (ck_rise) begin
        if (cmd_q.act) begin
          bank_open_q <= 1'b1;
        end else if (cmd_q.pre) begin
          bank_open_q <= 1'b0;
        end
        if (cmd_q.act || cmd_q.pde || cmd_q.sre) begin
          ref_tree_q <= 1'b0; // [RQ15]
        end else if (cmd_q.ref_cmd && !mode_q.no_ref_train) begin
          ref_tree_q <= 1'b1;
        end
        if (cmd_q.pde || cmd_q.sre) begin
          in_pd_q <= 1'b1;
        end else if (cmd_q.pdx) begin
          in_pd_q <= 1'b0;
        end
      end
      o_wck_tree_en <= bank_open_q || ref_tree_q;
    end
  end

  // Only normal reads touch the array; training commands use the read FIFO.
  // Read latency is counted in CK edges, so any WCK offset shifts the data.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_array_access <= 1'b0;
      o_rd_data_start <= 1'b0;
      lat_cnt_q <= 4'h0;
      lat_run_q <= 1'b0;
    end else begin
      o_array_access <= ck_rise && cmd_q.rd; // [RQ17]
      o_rd_data_start <= 1'b0;
      if (ck_rise) begin
        if (cmd_q.rd || cmd_q.train_read) begin
          lat_run_q <= 1'b1;
          lat_cnt_q <= lat_q; // [RQ10]
        end else if (lat_run_q) begin
          if (lat_cnt_q <= 4'h1) begin
            lat_run_q <= 1'b0;
            o_rd_data_start <= 1'b1; // [RQ10]
          end else begin
            lat_cnt_q <= lat_cnt_q - 4'h1;
          end
        end
      end
    end
  end

  // APB slave: one wait state, unmapped addresses answer with pslverr.
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && !o_pready;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      mode_q <= wat_pkg::MODE_RESET;
      lat_q <= wat_pkg::LAT_RESET;
    end else begin
      o_pready <= access;
      o_pslverr <= 1'b0;
      if (access) begin
        o_prdata <= 32'h0000_0000;
        unique case (i_paddr)
          wat_pkg::ADDR_MODE: begin
            if (i_pwrite) begin
              mode_q <= i_pwdata[10:0]; // [RQ24]
            end
            o_prdata <= {21'h000000, mode_q};
          end
          wat_pkg::ADDR_STATUS: begin
            o_prdata <= {24'h000000, autosync_ok, in_pd_q, ref_tree_q, bank_open_q,
                         stopped, early_q};
          end
          wat_pkg::ADDR_CKPER: begin
            o_prdata <= {16'h0000, ck_per_q};
          end
          wat_pkg::ADDR_LAT: begin
            if (i_pwrite) begin
              lat_q <= i_pwdata[3:0];
            end
            o_prdata <= {28'h0000000, lat_q};
          end
          default: begin
            o_pslverr <= 1'b1;
          end
        endcase
      end
      if (setup) begin
        o_pready <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/wat_top_sva.sv */
// Checker of the EDC, command and clock-tree outputs.
`timescale 1ns/1ns
module wat_top_sva (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic i_ck,
  input wire wat_pkg::wat_cmd_t i_cmd,
  input wire logic o_edc0,
  input wire logic o_edc2,
  input wire logic o_array_access,
  input wire logic o_rd_data_start,
  input wire logic o_wck_tree_en
);
  logic wr_mode;
  logic tr_q;
  logic [3:0] age_q [9];
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  assign wr_mode = i_psel && i_penable && !o_pready && i_pwrite && i_paddr == wat_pkg::ADDR_MODE;
  // The shadow is taken on the access edge, the same edge the register uses.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tr_q <= 1'b0;
    end else if (wr_mode) begin
      tr_q <= i_pwdata[wat_pkg::MODE_TRAIN];
    end
  end
  // Each command bit leaves a short trace, so an output can be tied to a recent cause.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 9; i++) begin
        age_q[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (i_cmd[i]) begin
          age_q[i] <= 4'hf;
        end else if (age_q[i] != 4'h0) begin
          age_q[i] <= age_q[i] - 4'h1;
        end
      end
    end
  end
  a_edc_idle_high: assert property (!tr_q ##1 !tr_q |-> o_edc0 && o_edc2)
    else $error("edc not high outside training");
  a_edc0_on_ck: assert property (tr_q && $changed(o_edc0) |-> $past(i_ck, 2))
    else $error("edc0 moved away from a ck rise");
  a_edc2_on_ck: assert property (tr_q && $changed(o_edc2) |-> $past(i_ck, 2))
    else $error("edc2 moved away from a ck rise");
  a_array_cause: assert property (o_array_access |-> age_q[2] != 4'h0)
    else $error("array access without a normal read");
  a_array_pulse: assert property (o_array_access |=> !o_array_access)
    else $error("array access longer than one cycle");
  a_start_pulse: assert property (o_rd_data_start |=> !o_rd_data_start)
    else $error("data start longer than one cycle");
  a_tree_rise: assert property ($rose(o_wck_tree_en) |->
    age_q[8] != 4'h0 || age_q[6] != 4'h0)
    else $error("tree enabled without activate or refresh");
  a_tree_fall: assert property ($fell(o_wck_tree_en) |->
    age_q[7] != 4'h0 || age_q[5] != 4'h0 || age_q[3] != 4'h0)
    else $error("tree dropped without a cause");
endmodule

/* File: testbench/wat_ctrl_model.sv */
// Controller-side model driving CK, both WCK pairs and held command pins.
`timescale 1ns/1ns
module wat_ctrl_model (
  input wire logic i_run01,
  input wire logic i_run23,
  output logic o_ck,
  output logic o_wck01,
  output logic o_wck23,
  output wat_pkg::wat_cmd_t o_cmd
);
  logic [1:0] step_q;
  initial begin
    step_q = 2'h0;
    o_ck = 1'b0;
    o_wck01 = 1'b0;
    o_wck23 = 1'b0;
    o_cmd = '0;
    #3;
    // Lone device: WCK and chip select unshared, each pair kept at its ideal phase.
    // Hence no midpoint and no soft select are needed.
    forever begin
      #20;
      step_q = step_q + 2'h1;
      o_ck = step_q[1];
      // A stopped pair parks its true line low and restarts on a whole cycle.
      o_wck01 = i_run01 & step_q[0];
      o_wck23 = i_run23 & step_q[0];
    end
  end
  task automatic send(input wat_pkg::wat_cmd_t c);
    @(negedge o_ck);
    o_cmd = c;
    @(negedge o_ck);
    o_cmd = '0;
    // Four whole CK periods cover every spacing, nanosecond ones rounded up.
    repeat (4) @(posedge o_ck);
  endtask
endmodule

/* File: testbench/tb_top.sv */
// Bench for the alignment and read-training block.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic we;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } wat_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ck, w01, w23;
  logic edc0, edc2, acc, start, tree, run01, run23, er, e0, e2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wat_pkg::wat_cmd_t cmd;
  int err_total = 0;
  int n_compared = 0;
  int n_acc = 0;
  int n_start = 0;
  time t_acc, t_start;
  wat_row_t rows [5] = '{
    '{wat_pkg::ADDR_MODE, 1'b0, 32'h0, 32'h0, 1'b0},
    '{wat_pkg::ADDR_LAT, 1'b0, 32'h0, {28'h0, wat_pkg::LAT_RESET}, 1'b0},
    '{wat_pkg::ADDR_LAT, 1'b1, 32'hffff_fff1, 32'h1, 1'b0},
    '{wat_pkg::ADDR_MODE, 1'b1, 32'hffff_f800, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'hffff_ffff, 32'h0, 1'b1}};
  wat_top dut (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ck(ck), .i_wck01(w01), .i_wck23(w23),
    .i_cmd(cmd), .o_edc0(edc0), .o_edc2(edc2), .o_array_access(acc),
    .o_rd_data_start(start), .o_wck_tree_en(tree));
  wat_ctrl_model u_model (.i_run01(run01), .i_run23(run23), .o_ck(ck), .o_wck01(w01),
    .o_wck23(w23), .o_cmd(cmd));
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        err_total++;
        final_report();
      end
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ckw(input int n);
    repeat (n) @(posedge ck);
    repeat (5) @(posedge clk);
  endtask
  task automatic go(input int b);
    wat_pkg::wat_cmd_t c;
    c = '0;
    c[b] = 1'b1;
    u_model.send(c);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A stalled wait would hang the run, so a cycle budget ends it as a failure.
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    final_report();
  end
  always @(posedge clk) begin
    if (acc === 1'b1) begin
      n_acc++;
      t_acc = $time;
    end
    if (start === 1'b1) begin
      n_start++;
      t_start = $time;
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run01 = 1'b1;
    run23 = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(edc0 & edc2), 32'h1);
    chk(32'(tree), 32'h0);
    foreach (rows[i]) begin
      if (rows[i].we) begin
        apb(rows[i].addr, 1'b1, rows[i].wd, rd, er);
      end
      apb(rows[i].addr, 1'b0, 32'h0, rd, er);
      chk(rd, rows[i].exp);
      chk(32'(er), 32'(rows[i].err));
    end
    // Training on, one WCK01 edge dropped, which leaves the WCK01 divider out of phase with WCK23.
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h1, rd, er);
    run01 <= 1'b0;
    repeat (5) @(posedge clk);
    run01 <= 1'b1;
    ckw(3);
    chk(32'(edc0), 32'(!edc2));
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h0, rd, er);
    run01 <= 1'b0;
    run23 <= 1'b0;
    // Both pairs rest past the stop count, with auto-sync left clear.
    repeat (20) @(posedge clk);
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h1, rd, er);
    repeat (20) @(posedge clk);
    run01 <= 1'b1;
    run23 <= 1'b1;
    ckw(3);
    chk(32'(edc0), 32'(edc2));
    e0 = edc0;
    e2 = edc2;
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h3, rd, er);
    ckw(2);
    chk(32'(edc0), 32'(!e0));
    chk(32'(edc2), 32'(e2));
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h7, rd, er);
    ckw(2);
    chk(32'(edc2), 32'(!e2));
    // Training is left while aligned; read and write inversion and check enables are set.
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h780, rd, er);
    repeat (3) @(posedge clk);
    chk(32'(edc0 & edc2), 32'h1);
    go(6);
    chk(32'(tree), 32'h1);
    go(5);
    chk(32'(tree), 32'h0);
    go(4);
    // An open bank lets the training commands below run.
    go(8);
    chk(32'(tree), 32'h1);
    go(2);
    chk(32'(n_acc), 32'h1);
    chk(32'(t_start - t_acc > 56 && t_start - t_acc < 104), 32'h1);
    go(1);
    go(0);
    chk(32'(n_acc), 32'h1);
    chk(32'(n_start), 32'h2);
    go(7);
    chk(32'(tree), 32'h0);
    apb(wat_pkg::ADDR_CKPER, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_000a);
    // Knock WCK01 out of phase, then let auto-sync realign both dividers in power-down.
    run01 <= 1'b0;
    repeat (5) @(posedge clk);
    run01 <= 1'b1;
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h18, rd, er);
    go(5);
    run01 <= 1'b0;
    run23 <= 1'b0;
    repeat (20) @(posedge clk);
    run01 <= 1'b1;
    run23 <= 1'b1;
    go(4);
    // After the exit only a brief training entry follows, no phase search.
    apb(wat_pkg::ADDR_MODE, 1'b1, 32'h19, rd, er);
    ckw(2);
    chk(32'(edc0), 32'(edc2));
    go(8);
    apb(wat_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, er);
    chk(rd & 32'h0000_00f0, 32'h0000_0090);
    // A second reset in mid-run leaves training and closes the bank.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(tree), 32'h0);
    chk(32'(edc0 & edc2), 32'h1);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(wat_pkg::ADDR_MODE, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0000_0000);
    final_report();
  end
endmodule
bind wat_top wat_top_sva u_sva (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .i_ck(i_ck), .i_cmd(i_cmd), .o_edc0(o_edc0), .o_edc2(o_edc2),
  .o_array_access(o_array_access), .o_rd_data_start(o_rd_data_start),
  .o_wck_tree_en(o_wck_tree_en));
